// [cwd_pkg.sv]
/*
  Shared constants and types for the complementary wave generator with dead band and auto-shutdown.
  Assumes an 8-bit register port and one synchronous clock domain.
*/
package cwd_pkg;

  // Register port widths, dead-band count width and fault source count.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DB_W = 6;
  localparam int NSRC = 7;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DBR = 8'h04;
  localparam logic [7:0] ADDR_DBF = 8'h08;
  localparam logic [7:0] ADDR_SDCTL = 8'h0c;
  localparam logic [7:0] ADDR_SDSRC = 8'h10;
  localparam logic [7:0] ADDR_CLKSEL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // Field positions.
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_LD_BIT = 6;
  localparam int SD_BIT = 7;
  localparam int REN_BIT = 6;
  localparam int LSBD_LSB = 4;
  localparam int LSAC_LSB = 2;
  localparam int CS_BIT = 0;
  localparam int STAT_IN_BIT = 1;
  localparam int STAT_IF_BIT = 0;

  // Reset values.
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [5:0] DB_RST = 6'h00;
  localparam logic [1:0] LVL_RST = 2'h0;
  localparam logic [6:0] SRC_RST = 7'h00;

  // Override level codes.
  localparam logic [1:0] LVL_HIZ = 2'h0;
  localparam logic [1:0] LVL_INACT = 2'h1;
  localparam logic [1:0] LVL_LOW = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;

  // Output mode codes.
  typedef enum logic [2:0] {
    MODE_ASYNC_STEER = 3'h0,
    MODE_SYNC_STEER = 3'h1,
    MODE_FWD_FULL = 3'h2,
    MODE_REV_FULL = 3'h3,
    MODE_HALF = 3'h4,
    MODE_PUSH_PULL = 3'h5
  } cwd_mode_t;

  // Generator states, one-hot.
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_SHUT = 3'h2,
    ST_RUN = 3'h4
  } cwd_state_t;

  // The four outputs travel together.
  typedef struct packed {
    logic fourth;
    logic third;
    logic second;
    logic first;
  } cwd_outs_t;

endpackage

// [cwd_deadband.sv]
/*
  One dead-band delay: output follows a rising level after a programmed count.
  Assumes the trigger level is synchronous to the clock.
*/
`timescale 1ns/1ps
module cwd_deadband #(
  parameter int W = 6
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Trigger level and active count.
  input wire logic level_i,
  input wire logic [W-1:0] count_i,
  // Delayed level.
  output logic out_o
);

  logic lvl_q;
  logic busy_q;
  logic [W-1:0] cnt_q;
  logic out_q;

  // Remembers the trigger level for edge detection.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= level_i;
    end
  end

  // Counts from the edge; an early level drop cancels the pulse.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (!level_i) begin
      busy_q <= 1'b0; // [RQ5]
      out_q <= 1'b0;
    end else if (!lvl_q) begin
      cnt_q <= '0; // [RQ4]
      busy_q <= (count_i != '0);
      out_q <= (count_i == '0); // [RQ4]
    end else if (busy_q) begin
      cnt_q <= W'(cnt_q + 1'b1); // [RQ25]
      if (cnt_q == W'(count_i - 1'b1)) begin
        busy_q <= 1'b0;
        out_q <= 1'b1; // [RQ3] [RQ8]
      end
    end
  end

  assign out_o = out_q;

endmodule

// [cwd_shutdown.sv]
/*
  Shutdown bit keeper: software and fault inputs set it, software or auto-restart clears it.
  Assumes fault inputs are synchronous to the clock.
*/
`timescale 1ns/1ps
module cwd_shutdown #(
  parameter int NSRC = cwd_pkg::NSRC
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Control.
  input wire logic en_rise_i,
  input wire logic ren_i,
  input wire logic sw_wr_i,
  input wire logic sw_val_i,
  // Fault sources.
  input wire logic [NSRC-1:0] fault_n_i,
  input wire logic [NSRC-1:0] src_en_i,
  // Status.
  output logic hw_active_o,
  output logic sd_o,
  output logic sd_set_o
);

  logic sd_q;
  logic sd_d;

  // Any enabled low fault input raises the hardware condition.
  assign hw_active_o = |(~fault_n_i & src_en_i); // [RQ12] [RQ26] [RQ13]

  // Sets win over every clear; clears need all sources gone.
  always_comb begin
    sd_d = sd_q;
    if (sw_wr_i && !sw_val_i && !hw_active_o) begin
      sd_d = 1'b0; // [RQ17] [RQ18] [RQ16]
    end
    if (ren_i && !hw_active_o) begin
      sd_d = 1'b0; // [RQ10] [RQ19] [RQ16]
    end
    if ((sw_wr_i && sw_val_i) || hw_active_o || en_rise_i) begin
      sd_d = 1'b1; // [RQ9] [RQ11] [RQ21]
    end
  end

  // Holds the shutdown bit.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sd_q <= 1'b0;
    end else begin
      sd_q <= sd_d;
    end
  end

  assign sd_o = sd_q;
  assign sd_set_o = sd_d & ~sd_q; // [RQ15]

endmodule

// [cwd_generator.sv]
/*
  Wave generator core: register port, buffered dead bands and output modes,
  auto-shutdown with override levels.
  Assumes the modulated data input and fault inputs are synchronous to mclk_i.
*/
`timescale 1ns/1ps
// Function
// RQ1 - Half-bridge: falling dead band delays second output.
// RQ2 - Forward dead band only on reverse-to-forward change, fourth output.
// RQ3 - Falling count gives dead band in clock periods.
// RQ4 - Count starts on data edge; zero means no dead band.
// RQ5 - Early data reversal suppresses the pulse.
// RQ6 - Falling count double-buffered; disabled writes load at once.
// RQ7 - Enabled: load on rise after first fall after request.
// RQ8 - Dead band is count to count plus one periods.
// RQ9 - Software shutdown bit holds shutdown while set.
// RQ10 - Auto-restart clears software shutdown; resume on rise.
// RQ11 - Enabled fault forces override levels at once.
// RQ12 - Faults are active low, each individually enabled.
// RQ13 - Faults are level sensitive; shutdown holds while active.
// RQ14 - Two override fields: second/fourth and first/third.
// RQ15 - Any shutdown set raises the interrupt flag; the code raises it only while enabled, not for the set at enable.
// RQ16 - Restart waits until every source is clear.
// RQ17 - Software clears shutdown; resume on next rise.
// RQ18 - Software clear ignored while a fault is present.
// RQ19 - Auto-restart clears shutdown when faults go; resume on rise.
// RQ20 - Fast oscillator kept on while enabled, active and selected.
// RQ21 - Enable starts in shutdown with override levels.
// RQ22 - Software configures while disabled, enable last.
// RQ23 - Mode field picks push-pull, half, full or steering.
// RQ24 - Load request self-clears; settable only once enabled.
// RQ25 - Six-bit rising and falling counters count up to value.
// RQ26 - Hardware shutdown is OR of enabled inverted faults.
module cwd_generator #(
  parameter int NSRC = cwd_pkg::NSRC,
  parameter int DB_W = cwd_pkg::DB_W
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register port.
  input wire logic [cwd_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [cwd_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [cwd_pkg::DATA_W-1:0] reg_rdata_o,
  // Modulated data and faults.
  input wire logic mod_data_i,
  input wire logic input_active_i,
  input wire logic [NSRC-1:0] fault_n_i,
  // Outputs to the switch drivers.
  output cwd_pkg::cwd_outs_t gen_out_o,
  output cwd_pkg::cwd_outs_t gen_oe_n_o,
  // Status.
  output logic gen_irq_flag_o,
  output logic osc_keep_on_o
);

  // Software-visible state.
  logic en_q;
  logic ld_q;
  cwd_pkg::cwd_mode_t mode_q;
  logic [DB_W-1:0] dbr_wr_q;
  logic [DB_W-1:0] dbf_wr_q;
  logic [DB_W-1:0] dbr_act_q;
  logic [DB_W-1:0] dbf_act_q;
  logic ren_q;
  logic [1:0] lsbd_q;
  logic [1:0] lsac_q;
  logic [NSRC-1:0] src_en_q;
  logic cs_q;
  logic irq_q;
  logic [cwd_pkg::DATA_W-1:0] rdata_q;

  // Internal state.
  cwd_pkg::cwd_state_t state_q;
  logic data_q;
  logic ld_fall_seen_q;
  logic phase_q;
  logic rev_dir_q;
  logic fwd_pend_q;
  logic rev_pend_q;
  cwd_pkg::cwd_outs_t out_q;
  cwd_pkg::cwd_outs_t oe_n_q;
  cwd_pkg::cwd_outs_t run_d;

  // Decoded strobes and events.
  logic wr_ctrl;
  logic wr_sdctl;
  logic data_rise;
  logic data_fall;
  logic en_rise;
  logic hw_active;
  logic sd_bit;
  logic sd_set;
  logic dbr_out;
  logic dbf_out;
  logic dbf_level;
  logic is_full;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == cwd_pkg::ADDR_CTRL);
  assign wr_sdctl = reg_wr_i && (reg_addr_i == cwd_pkg::ADDR_SDCTL);
  assign data_rise = mod_data_i & ~data_q;
  assign data_fall = ~mod_data_i & data_q;
  assign en_rise = wr_ctrl && reg_wdata_i[cwd_pkg::CTRL_EN_BIT] && !en_q;
  assign is_full = (mode_q == cwd_pkg::MODE_FWD_FULL) || (mode_q == cwd_pkg::MODE_REV_FULL);

  // Data edge history.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_q <= 1'b0;
    end else begin
      data_q <= mod_data_i;
    end
  end

  // Control register: enable and mode.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_q <= 1'b0;
      mode_q <= cwd_pkg::cwd_mode_t'(cwd_pkg::MODE_RST);
    end else if (wr_ctrl) begin
      en_q <= reg_wdata_i[cwd_pkg::CTRL_EN_BIT];
      mode_q <= cwd_pkg::cwd_mode_t'(reg_wdata_i[2:0]); // [RQ23]
    end
  end

  // Load request: settable only when already enabled, cleared by the transfer or by disabling.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ld_q <= 1'b0;
      ld_fall_seen_q <= 1'b0;
    end else if (!en_q) begin
      ld_q <= 1'b0;
      ld_fall_seen_q <= 1'b0;
    end else if (ld_q && ld_fall_seen_q && data_rise) begin
      ld_q <= 1'b0; // [RQ24]
      ld_fall_seen_q <= 1'b0;
    end else begin
      if (ld_q && data_fall) begin
        ld_fall_seen_q <= 1'b1; // [RQ7]
      end
      if (wr_ctrl && reg_wdata_i[cwd_pkg::CTRL_LD_BIT] && !ld_q) begin
        ld_q <= 1'b1; // [RQ24]
        ld_fall_seen_q <= 1'b0;
      end
    end
  end

  // Written dead-band counts.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dbr_wr_q <= cwd_pkg::DB_RST;
      dbf_wr_q <= cwd_pkg::DB_RST;
    end else if (reg_wr_i && reg_addr_i == cwd_pkg::ADDR_DBR) begin
      dbr_wr_q <= reg_wdata_i[DB_W-1:0];
    end else if (reg_wr_i && reg_addr_i == cwd_pkg::ADDR_DBF) begin
      dbf_wr_q <= reg_wdata_i[DB_W-1:0];
    end
  end

  // Active dead-band counts: follow writes while disabled, else transfer on the load edge.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dbr_act_q <= cwd_pkg::DB_RST;
      dbf_act_q <= cwd_pkg::DB_RST;
    end else if (!en_q) begin
      if (reg_wr_i && reg_addr_i == cwd_pkg::ADDR_DBR) begin
        dbr_act_q <= reg_wdata_i[DB_W-1:0];
      end
      if (reg_wr_i && reg_addr_i == cwd_pkg::ADDR_DBF) begin
        dbf_act_q <= reg_wdata_i[DB_W-1:0]; // [RQ6]
      end
    end else if (ld_q && ld_fall_seen_q && data_rise) begin
      dbr_act_q <= dbr_wr_q;
      dbf_act_q <= dbf_wr_q; // [RQ7]
    end
  end

  // Shutdown control, source enables and clock select.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ren_q <= 1'b0;
      lsbd_q <= cwd_pkg::LVL_RST;
      lsac_q <= cwd_pkg::LVL_RST;
      src_en_q <= NSRC'(cwd_pkg::SRC_RST);
      cs_q <= 1'b0;
    end else if (wr_sdctl) begin
      ren_q <= reg_wdata_i[cwd_pkg::REN_BIT];
      lsbd_q <= reg_wdata_i[cwd_pkg::LSBD_LSB +: 2];
      lsac_q <= reg_wdata_i[cwd_pkg::LSAC_LSB +: 2];
    end else if (reg_wr_i && reg_addr_i == cwd_pkg::ADDR_SDSRC) begin
      src_en_q <= reg_wdata_i[NSRC-1:0];
    end else if (reg_wr_i && reg_addr_i == cwd_pkg::ADDR_CLKSEL) begin
      cs_q <= reg_wdata_i[cwd_pkg::CS_BIT];
    end
  end

  // Shutdown bit keeper.
  cwd_shutdown #(
    .NSRC(NSRC)
  ) u_shutdown (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .en_rise_i(en_rise),
    .ren_i(ren_q),
    .sw_wr_i(wr_sdctl && en_q),
    .sw_val_i(reg_wdata_i[cwd_pkg::SD_BIT]),
    .fault_n_i(fault_n_i),
    .src_en_i(src_en_q),
    .hw_active_o(hw_active),
    .sd_o(sd_bit),
    .sd_set_o(sd_set)
  );

  // Interrupt flag: shutdown sets, writing one clears; set wins.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_q <= 1'b0;
    end else if (sd_set && en_q) begin
      irq_q <= 1'b1; // [RQ15]
    end else if (reg_wr_i && reg_addr_i == cwd_pkg::ADDR_STATUS && reg_wdata_i[cwd_pkg::STAT_IF_BIT]) begin
      irq_q <= 1'b0;
    end
  end

  // Generator state; restart only on a data rising edge.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= cwd_pkg::ST_OFF;
    end else begin
      case (state_q)
        cwd_pkg::ST_OFF: begin
          if (en_q) begin
            state_q <= cwd_pkg::ST_SHUT; // [RQ21]
          end
        end
        cwd_pkg::ST_SHUT: begin
          if (!en_q) begin
            state_q <= cwd_pkg::ST_OFF;
          end else if (!sd_bit && !hw_active && data_rise) begin
            state_q <= cwd_pkg::ST_RUN; // [RQ17] [RQ19] [RQ10]
          end
        end
        cwd_pkg::ST_RUN: begin
          if (!en_q) begin
            state_q <= cwd_pkg::ST_OFF;
          end else if (sd_bit || hw_active) begin
            state_q <= cwd_pkg::ST_SHUT; // [RQ9] [RQ11] [RQ13]
          end
        end
        default: begin
          state_q <= cwd_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Direction, push-pull phase and pending direction-change dead bands.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_q <= 1'b0;
      rev_dir_q <= 1'b0;
      fwd_pend_q <= 1'b0;
      rev_pend_q <= 1'b0;
    end else if (data_rise) begin
      phase_q <= ~phase_q;
      if (is_full) begin
        rev_dir_q <= (mode_q == cwd_pkg::MODE_REV_FULL);
        fwd_pend_q <= rev_dir_q && (mode_q == cwd_pkg::MODE_FWD_FULL); // [RQ2]
        rev_pend_q <= !rev_dir_q && (mode_q == cwd_pkg::MODE_REV_FULL);
      end
    end else if (data_fall) begin
      fwd_pend_q <= 1'b0;
      rev_pend_q <= 1'b0;
    end
  end

  // Falling counter: data fall in half-bridge, forward change otherwise.
  assign dbf_level = (mode_q == cwd_pkg::MODE_HALF) ? ~mod_data_i : mod_data_i;

  cwd_deadband #(
    .W(DB_W)
  ) u_db_rise (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .level_i(mod_data_i),
    .count_i(dbr_act_q),
    .out_o(dbr_out)
  );

  cwd_deadband #(
    .W(DB_W)
  ) u_db_fall (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .level_i(dbf_level),
    .count_i(dbf_act_q),
    .out_o(dbf_out)
  );

  // Running output levels for each mode.
  always_comb begin
    run_d = '0;
    case (mode_q)
      cwd_pkg::MODE_HALF: begin
        run_d.first = dbr_out;
        run_d.second = dbf_out; // [RQ1]
      end
      cwd_pkg::MODE_PUSH_PULL: begin
        run_d.first = mod_data_i & ~phase_q;
        run_d.second = mod_data_i & phase_q;
      end
      cwd_pkg::MODE_FWD_FULL, cwd_pkg::MODE_REV_FULL: begin
        run_d.first = ~rev_dir_q;
        run_d.third = rev_dir_q;
        run_d.fourth = ~rev_dir_q & (fwd_pend_q ? dbf_out : mod_data_i); // [RQ2]
        run_d.second = rev_dir_q & (rev_pend_q ? dbr_out : mod_data_i);
      end
      cwd_pkg::MODE_ASYNC_STEER, cwd_pkg::MODE_SYNC_STEER: begin
        run_d = {4{mod_data_i}};
      end
      default: begin
        run_d = '0;
      end
    endcase
  end

  // Override level decode for one output.
  function automatic logic ovr_level(input logic [1:0] code);
    ovr_level = (code == cwd_pkg::LVL_HIGH);
  endfunction

  // Output registers: override levels while shut down or faulted.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_q <= '0;
      oe_n_q <= '1;
    end else if (state_q == cwd_pkg::ST_OFF || !en_q) begin
      out_q <= '0;
      oe_n_q <= '1;
    end else if (state_q == cwd_pkg::ST_SHUT || hw_active || sd_bit) begin
      out_q.first <= ovr_level(lsac_q); // [RQ14] [RQ11]
      out_q.third <= ovr_level(lsac_q);
      out_q.second <= ovr_level(lsbd_q);
      out_q.fourth <= ovr_level(lsbd_q);
      oe_n_q.first <= (lsac_q == cwd_pkg::LVL_HIZ);
      oe_n_q.third <= (lsac_q == cwd_pkg::LVL_HIZ);
      oe_n_q.second <= (lsbd_q == cwd_pkg::LVL_HIZ);
      oe_n_q.fourth <= (lsbd_q == cwd_pkg::LVL_HIZ);
    end else begin
      out_q <= run_d;
      oe_n_q <= '0;
    end
  end

  // Read data register, valid the cycle after the read strobe.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i) begin
      if (reg_addr_i == cwd_pkg::ADDR_CTRL) begin
        rdata_q <= {en_q, ld_q, 3'h0, mode_q};
      end else if (reg_addr_i == cwd_pkg::ADDR_DBR) begin
        rdata_q <= 8'(dbr_wr_q);
      end else if (reg_addr_i == cwd_pkg::ADDR_DBF) begin
        rdata_q <= 8'(dbf_wr_q);
      end else if (reg_addr_i == cwd_pkg::ADDR_SDCTL) begin
        rdata_q <= {sd_bit, ren_q, lsbd_q, lsac_q, 2'h0};
      end else if (reg_addr_i == cwd_pkg::ADDR_SDSRC) begin
        rdata_q <= 8'(src_en_q);
      end else if (reg_addr_i == cwd_pkg::ADDR_CLKSEL) begin
        rdata_q <= {7'h00, cs_q};
      end else if (reg_addr_i == cwd_pkg::ADDR_STATUS) begin
        rdata_q <= {6'h00, mod_data_i, irq_q};
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Keeps the oscillator on for sleep.
  always_comb begin
    osc_keep_on_o = en_q && input_active_i && cs_q; // [RQ20]
  end

  assign reg_rdata_o = rdata_q;
  assign gen_out_o = out_q;
  assign gen_oe_n_o = oe_n_q;
  assign gen_irq_flag_o = irq_q;

endmodule

// [cwd_gen_properties.sv]
/* Concurrent checks on the generator ports.
   Assumes a bind to cwd_generator. */
`timescale 1ns/1ps
module cwd_gen_properties #(
  parameter int NSRC = cwd_pkg::NSRC,
  parameter int DB_W = cwd_pkg::DB_W
) (
  // Clock, reset and register port.
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [cwd_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [cwd_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [cwd_pkg::DATA_W-1:0] reg_rdata_o,
  // Data, faults and outputs.
  input wire logic mod_data_i,
  input wire logic input_active_i,
  input wire logic [NSRC-1:0] fault_n_i,
  input wire cwd_pkg::cwd_outs_t gen_out_o,
  input wire cwd_pkg::cwd_outs_t gen_oe_n_o,
  input wire logic gen_irq_flag_o,
  input wire logic osc_keep_on_o
);
  logic en_q, cs_q, rdc_q, hw, ovr_ok;
  logic [2:0] mode_q;
  logic [1:0] bd_q, ac_q;
  logic [NSRC-1:0] src_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Shadow of the written configuration.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_q <= 1'b0;
      cs_q <= 1'b0;
      mode_q <= 3'h0;
      bd_q <= 2'h0;
      ac_q <= 2'h0;
      src_q <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == cwd_pkg::ADDR_CTRL) begin
        en_q <= reg_wdata_i[7];
        mode_q <= reg_wdata_i[2:0];
      end
      if (reg_addr_i == cwd_pkg::ADDR_SDCTL) begin
        bd_q <= reg_wdata_i[5:4];
        ac_q <= reg_wdata_i[3:2];
      end
      if (reg_addr_i == cwd_pkg::ADDR_SDSRC) begin
        src_q <= reg_wdata_i[NSRC-1:0];
      end
      if (reg_addr_i == cwd_pkg::ADDR_CLKSEL) begin
        cs_q <= reg_wdata_i[0];
      end
    end
  end

  // Marks when control read data is due.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdc_q <= 1'b0;
    end else begin
      rdc_q <= reg_rd_i && (reg_addr_i == cwd_pkg::ADDR_CTRL);
    end
  end

  // Fault condition and the expected override pattern.
  assign hw = |(~fault_n_i & src_q);
  assign ovr_ok = (gen_oe_n_o == {bd_q == 2'h0, ac_q == 2'h0, bd_q == 2'h0, ac_q == 2'h0})
    && (gen_out_o == {bd_q == 2'h3, ac_q == 2'h3, bd_q == 2'h3, ac_q == 2'h3});

  a_keep_on_level: assert property (
    osc_keep_on_o == (en_q && input_active_i && cs_q)) else $error("keep-on level wrong");
  a_fault_override: assert property (
    (en_q && hw) [*2] |=> ovr_ok) else $error("no fault override");
  a_enable_start: assert property (
    $rose(en_q) |-> ##2 ovr_ok) else $error("no shutdown start");
  a_off_undriven: assert property (
    !en_q [*2] |-> gen_oe_n_o == 4'hf) else $error("driven while off");
  a_irq_needs_en: assert property (
    $rose(gen_irq_flag_o) |-> en_q) else $error("flag while off");
  a_irq_sticky: assert property (
    gen_irq_flag_o && !(reg_wr_i && reg_addr_i == cwd_pkg::ADDR_STATUS && reg_wdata_i[0])
    |=> gen_irq_flag_o) else $error("flag lost");
  a_half_no_overlap: assert property (
    mode_q == 3'h4 && !(bd_q == 2'h3 && ac_q == 2'h3)
    |-> !(gen_out_o.first && gen_out_o.second && !gen_oe_n_o.first && !gen_oe_n_o.second))
    else $error("half overlap");
  a_ctrl_readback: assert property (
    rdc_q |-> reg_rdata_o[2:0] == mode_q && reg_rdata_o[7] == en_q) else $error("bad readback");
endmodule

// [cwd_gate_drv.sv]
/* Gate driver model for the four bridge switches.
   Assumes a pull-down on each gate line while the generator leaves it undriven. */
`timescale 1ns/1ps
module cwd_gate_drv (
  // Clock and generator pins.
  input wire logic mclk_i,
  input wire cwd_pkg::cwd_outs_t gen_out_i,
  input wire cwd_pkg::cwd_outs_t gen_oe_n_i,
  // Gate levels and overlap count.
  output logic [3:0] gate_o,
  output int shoot_o
);
  // An undriven gate line falls to its pull-down level.
  assign gate_o = gen_out_i & ~gen_oe_n_i;

  // Counts cycles with both first-leg switches on.
  initial shoot_o = 0;
  always @(posedge mclk_i) begin
    if (gate_o[0] && gate_o[1]) begin
      shoot_o <= shoot_o + 1;
    end
  end
endmodule

// [testbench.sv]
/* Self-checking bench for the wave generator core.
   Assumes the core, checker and driver model compile first. */
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] CT = cwd_pkg::ADDR_CTRL;
  localparam logic [7:0] DF = cwd_pkg::ADDR_DBF;
  localparam logic [7:0] SD = cwd_pkg::ADDR_SDCTL;
  localparam logic [7:0] ST = cwd_pkg::ADDR_STATUS;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic mod_data_i = 1'b0;
  logic input_active_i = 1'b1;
  logic [6:0] fault_n_i = 7'h7f;
  cwd_pkg::cwd_outs_t gen_out_o;
  cwd_pkg::cwd_outs_t gen_oe_n_o;
  logic gen_irq_flag_o;
  logic osc_keep_on_o;
  logic [3:0] gate;
  int shoot;
  int n_errors = 0;
  int num_checks = 0;

  // Clock at 40 MHz.
  always #12.5 mclk_i = ~mclk_i;

  cwd_generator cwd_generator_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .mod_data_i(mod_data_i), .input_active_i(input_active_i), .fault_n_i(fault_n_i),
    .gen_out_o(gen_out_o), .gen_oe_n_o(gen_oe_n_o), .gen_irq_flag_o(gen_irq_flag_o),
    .osc_keep_on_o(osc_keep_on_o));
  cwd_gate_drv cwd_gate_drv_inst (.mclk_i(mclk_i), .gen_out_i(gen_out_o), .gen_oe_n_i(gen_oe_n_o),
    .gate_o(gate), .shoot_o(shoot));

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: %h != %h", $time, w, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string w);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o & m, e, w);
  endtask

  // Sets the data level, then lets k edges pass.
  task automatic dat(input logic v, input int k);
    @(posedge mclk_i);
    mod_data_i <= v;
    repeat (k) @(posedge mclk_i);
  endtask

  // Compares enables (high nibble) and levels (low nibble) under a mask.
  task automatic pins(input logic [7:0] m, input logic [7:0] e, input string w);
    #1;
    chk({gen_oe_n_o, gen_out_o} & m, e, w);
  endtask

  // Times the second output after data falls.
  task automatic db_chk(input int d);
    int k;
    k = 0;
    dat(1'b1, 80);
    mod_data_i <= 1'b0;
    do begin
      @(posedge mclk_i);
      #1;
      k++;
    end while (gen_out_o.second !== 1'b1 && k < 90);
    chk(8'((k >= d + 1) && (k <= d + 3)), 8'h01, "falling dead band");
  endtask

  initial begin
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(CT, 8'h00, 8'hff, "control reset");
    rd(SD, 8'h00, 8'hff, "shutdown reset");
    rd(8'h1c, 8'h00, 8'hff, "unmapped read");
    // Configure while disabled, enable last.
    wr(DF, 8'h00);
    rd(DF, 8'h00, 8'h3f, "count buffer");
    wr(SD, 8'h38);
    wr(cwd_pkg::ADDR_SDSRC, 8'h04);
    wr(cwd_pkg::ADDR_CLKSEL, 8'h01);
    wr(CT, 8'hc4);
    rd(CT, 8'h84, 8'hff, "load with enable");
    dat(1'b0, 3);
    pins(8'hff, 8'h0a, "start in shutdown");
    chk({7'h0, osc_keep_on_o}, 8'h01, "keep-on");
    dat(1'b0, 5);
    pins(8'hff, 8'h0a, "no resume before edge");
    $display("Test enable done");
    // Software clear, then dead-band lengths and buffer load.
    wr(SD, 8'h38);
    db_chk(0);
    wr(DF, 8'h06);
    wr(CT, 8'hc4);
    db_chk(0);
    db_chk(6);
    rd(CT, 8'h00, 8'h40, "load bit self-clears");
    dat(1'b1, 20);
    repeat (15) begin
      dat(1'b0, 2);
      dat(1'b1, 1);
      pins(8'h02, 8'h00, "suppressed pulse");
    end
    $display("Test dead band done");
    // Fault inputs, latch, refused clear and software restart.
    wr(ST, 8'h01);
    rd(ST, 8'h00, 8'h01, "flag cleared");
    fault_n_i <= 7'h7e;
    dat(1'b1, 5);
    pins(8'h11, 8'h01, "unselected fault ignored");
    fault_n_i <= 7'h7a;
    dat(1'b1, 3);
    pins(8'hff, 8'h0a, "fault override");
    rd(ST, 8'h01, 8'h01, "flag on fault");
    wr(SD, 8'h38);
    dat(1'b0, 3);
    dat(1'b1, 4);
    rd(SD, 8'h80, 8'h80, "clear refused");
    fault_n_i <= 7'h7f;
    dat(1'b1, 10);
    pins(8'hff, 8'h0a, "latched after fault");
    wr(SD, 8'h38);
    dat(1'b1, 3);
    pins(8'hff, 8'h0a, "wait for edge");
    dat(1'b0, 3);
    dat(1'b1, 4);
    pins(8'h11, 8'h01, "software restart");
    $display("Test fault done");
    // Auto-restart after the source enable is removed.
    wr(SD, 8'h78);
    fault_n_i <= 7'h7b;
    dat(1'b1, 3);
    pins(8'hff, 8'h0a, "fault with auto-restart");
    wr(cwd_pkg::ADDR_SDSRC, 8'h00);
    rd(SD, 8'h00, 8'h80, "auto clear");
    dat(1'b0, 3);
    dat(1'b1, 4);
    pins(8'h11, 8'h01, "auto resume");
    fault_n_i <= 7'h7f;
    // Software shutdown with and without auto-restart.
    wr(ST, 8'h01);
    wr(SD, 8'hf8);
    dat(1'b1, 2);
    pins(8'hff, 8'h0a, "software shutdown");
    rd(ST, 8'h01, 8'h01, "flag on software");
    rd(SD, 8'h00, 8'h80, "self clear");
    dat(1'b0, 3);
    dat(1'b1, 4);
    pins(8'h11, 8'h01, "resume on edge");
    wr(SD, 8'hb8);
    dat(1'b0, 3);
    dat(1'b1, 4);
    pins(8'hff, 8'h0a, "held shutdown");
    wr(SD, 8'h38);
    $display("Test shutdown done");
    // Reverse to forward change delays only the fourth output.
    wr(CT, 8'h83);
    dat(1'b0, 20);
    dat(1'b1, 20);
    dat(1'b0, 20);
    wr(CT, 8'h82);
    dat(1'b1, 3);
    pins(8'h08, 8'h00, "forward delay");
    dat(1'b1, 10);
    pins(8'h99, 8'h09, "forward running");
    chk(8'(shoot), 8'h00, "leg overlap");
    $display("Test full bridge done");
    final_report;
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    $display("[ERR] %0t run did not finish", $time);
    final_report;
  end
endmodule

bind cwd_generator cwd_gen_properties #(.NSRC(NSRC), .DB_W(DB_W)) cwd_gen_properties_inst (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mod_data_i(mod_data_i),
  .input_active_i(input_active_i), .fault_n_i(fault_n_i), .gen_out_o(gen_out_o),
  .gen_oe_n_o(gen_oe_n_o), .gen_irq_flag_o(gen_irq_flag_o), .osc_keep_on_o(osc_keep_on_o));
